// *** pkg/usb_flags_map.svh ***
// Register offsets, field positions, reset values and timing counts of the pipe event flag block
// Notes on behaviour
// - A token for pipe 0, 1 or 2 that meets a not-ready buffer sets that pipe's not-ready flag.
// - Not ready means a NAK was sent while the pipe's response select holds the buffer code 01.
// - A NAK sent in the status stage of a control transfer never sets the control pipe flag.
// - Writing zero to a not-ready or empty/size-error flag clears it.
// - Writing one to a flag bit leaves it as it was.
// - While the internal clock supply bit is zero, zero writes clear no flag.
// - One write may clear several set flags at once.
// - Empty/size-error status bits 6..1 serve pipes 6..1, bit 0 the control pipe, bits 15..7 read zero; not-ready status uses bits 2..0 only.
// - Hardware and software reset clear the status to zero; a USB bus reset does not.
// - A flag reads one while its event has happened and is not yet cleared.
// - An IN pipe sets its empty/size-error flag once its buffers are fully transmitted.
// - An OUT pipe that receives an oversize packet sets the flag and is forced to stall.
// - The control pipe checks received length against its seven-bit max packet size.
`ifndef USB_FLAGS_MAP_SVH
`define USB_FLAGS_MAP_SVH

`define OFS_CTRL 8'h60
`define OFS_RESP_SEL 8'h64
`define OFS_NOT_READY 8'h68
`define OFS_EMPTY_OVERSIZE 8'h6c
`define OFS_PIPE_CFG 8'h78
`define OFS_IRQ_MASK 8'h7c

`define CTRL_CLK_ON_BIT 0
`define CTRL_SOFT_RST_BIT 1
`define CFG_MAXPS_LSB 0
`define CFG_DIR_LSB 8
`define MASK_EMP_LSB 0
`define MASK_NRDY_LSB 8

`define RESP_BUF 2'h1
`define RESP_STALL 2'h2
`define RST_FLAGS 16'h0000
`define RST_CTRL 2'h1
`define RST_RESP_SEL 14'h0000
`define RST_CFG 16'h0040
`define RST_MASK 16'h0000

`define CLK_PERIOD_NS 5
`define CLR_SPACING_NS 100
`define CLR_SPACING_CYC ((`CLR_SPACING_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** pkg/usb_flags_pkg.sv ***
// Types shared by the pipe event flag block and its register port
package usb_flags_pkg;
  typedef struct packed {
    logic valid;
    logic [2:0] pipe;
    logic nak;
    logic status_stage;
  } token_evt_s;

  typedef struct packed {
    logic valid;
    logic [2:0] pipe;
    logic [10:0] len;
    logic over_max;
  } rx_evt_s;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_s;
endpackage

// *** design/axil_regs_port.sv ***
// AXI4-Lite slave front end: turns bus traffic into register write pulses and read lookups
`timescale 1ns/1ps
`default_nettype none
module axil_regs_port
  import usb_flags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output reg_wr_s wr_req,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_nxt, rvalid_nxt, arready_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  logic commit;

  // Both halves held and no response pending: commit exactly once
  assign commit = aw_held_r && w_held_r && !bvalid;
  assign wr_req = '{en: commit, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
  assign rd_addr = araddr;

  // Address and data may arrive in either order; each is held until the pair commits
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid;
    bresp_nxt = bresp;
    if (awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (commit) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_ok ? 2'h0 : 2'h2;
    end else if (bvalid && bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // One read in flight; data is sampled at the edge that takes the address
  always_comb begin
    arready_nxt = arready;
    rvalid_nxt = rvalid;
    rdata_nxt = rdata;
    rresp_nxt = rresp;
    if (arvalid && arready) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data;
      rresp_nxt = rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      // Ready is registered so the bus outputs come straight from flip-flops
      awready <= !aw_held_nxt;
      wready <= !w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid <= bvalid_nxt;
      bresp <= bresp_nxt;
      arready <= arready_nxt;
      rvalid <= rvalid_nxt;
      rdata <= rdata_nxt;
      rresp <= rresp_nxt;
    end
  end
endmodule
`default_nettype wire

// *** design/usb_pipe_buffer_event_flags.sv ***
// Pipe buffer not-ready and empty/size-error event flags with register access and interrupts
`timescale 1ns/1ps
`default_nettype none
`include "usb_flags_map.svh"
module usb_pipe_buffer_event_flags
  import usb_flags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire token_evt_s token_evt,
  input wire rx_evt_s rx_evt,
  input wire logic [6:0] tx_empty,
  input wire logic usb_bus_reset,
  output logic [13:0] pipe_response_select,
  output logic irq_not_ready,
  output logic irq_empty_oversize,
  output logic irq
);
  // Flag state and software controls
  logic [2:0] not_ready_r, not_ready_nxt;
  logic [6:0] empty_oversize_r, empty_oversize_nxt;
  logic [13:0] resp_sel_r, resp_sel_nxt;
  logic [6:0] dir_in_r, dir_in_nxt;
  logic [6:0] ctrl_pipe_max_packet_size_r, ctrl_pipe_max_packet_size_nxt;
  logic clk_on_r, clk_on_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic irq_nrdy_nxt, irq_emp_nxt, irq_nxt;
  logic irq_nrdy_r, irq_emp_r, irq_r;

  // Event vectors built per pipe
  logic [2:0] nrdy_set;
  logic [6:0] emp_set;
  logic [6:0] stall_force;

  // Register port wiring
  reg_wr_s wr_req;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] lane_mask;
  logic [31:0] wr_merged;
  logic soft_rst;
  logic clear_allowed;

  axil_regs_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_req(wr_req),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Byte lanes that were not strobed behave as ones, so they never clear a flag
  assign lane_mask = {{8{wr_req.strb[3]}}, {8{wr_req.strb[2]}},
                      {8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};
  assign wr_merged = (wr_req.data & lane_mask) | ~lane_mask;

  // With the internal clock stopped the flag logic cannot take a clear
  assign clear_allowed = clk_on_r;

  // Soft reset is a self-clearing command bit in the control register
  assign soft_rst = wr_req.en && (wr_req.addr == `OFS_CTRL) && wr_req.strb[0] &&
                    wr_req.data[`CTRL_SOFT_RST_BIT];

  // Not-ready events for the control pipe and pipes 1 and 2
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_nrdy
      // Token hit a pipe that answered NAK while in buffer-controlled response
      assign nrdy_set[gi] = token_evt.valid && (token_evt.pipe == 3'(gi)) && token_evt.nak &&
                            (resp_sel_r[2*gi +: 2] == `RESP_BUF) &&
                            !((gi == 0) && token_evt.status_stage);
    end
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_emp
      logic rx_hit;
      logic oversize;
      assign rx_hit = rx_evt.valid && (rx_evt.pipe == 3'(gi)) && !dir_in_r[gi];
      // Control pipe length is checked here; other pipes report it from the engine
      if (gi == 0) begin : g_ctrl
        assign oversize = rx_evt.len > {4'h0, ctrl_pipe_max_packet_size_r};
      end else begin : g_pipe
        assign oversize = rx_evt.over_max;
      end
      assign stall_force[gi] = rx_hit && oversize;
      assign emp_set[gi] = (tx_empty[gi] && dir_in_r[gi]) || stall_force[gi];
    end
  endgenerate

  // Flag next state: set wins over a clear in the same cycle
  always_comb begin
    not_ready_nxt = not_ready_r;
    empty_oversize_nxt = empty_oversize_r;
    if (wr_req.en && clear_allowed) begin
      // Only zero bits clear; ones and unstrobed lanes leave flags untouched
      if (wr_req.addr == `OFS_NOT_READY) begin
        not_ready_nxt = not_ready_r & wr_merged[2:0];
      end
      if (wr_req.addr == `OFS_EMPTY_OVERSIZE) begin
        empty_oversize_nxt = empty_oversize_r & wr_merged[6:0];
      end
    end
    not_ready_nxt = not_ready_nxt | nrdy_set;
    empty_oversize_nxt = empty_oversize_nxt | emp_set;
    // Software reset wipes both groups; a USB bus reset is deliberately not wired here
    if (soft_rst) begin
      not_ready_nxt = 3'(`RST_FLAGS);
      empty_oversize_nxt = 7'(`RST_FLAGS);
    end
  end

  // Software controls; a size error forces stall over any software write in the same cycle
  always_comb begin
    resp_sel_nxt = resp_sel_r;
    dir_in_nxt = dir_in_r;
    ctrl_pipe_max_packet_size_nxt = ctrl_pipe_max_packet_size_r;
    clk_on_nxt = clk_on_r;
    mask_nxt = mask_r;
    if (wr_req.en) begin
      case (wr_req.addr)
        `OFS_CTRL: begin
          if (wr_req.strb[0]) begin
            clk_on_nxt = wr_req.data[`CTRL_CLK_ON_BIT];
          end
        end
        `OFS_RESP_SEL: begin
          if (wr_req.strb[0]) begin
            resp_sel_nxt[7:0] = wr_req.data[7:0];
          end
          if (wr_req.strb[1]) begin
            resp_sel_nxt[13:8] = wr_req.data[13:8];
          end
        end
        `OFS_PIPE_CFG: begin
          if (wr_req.strb[0]) begin
            ctrl_pipe_max_packet_size_nxt = wr_req.data[`CFG_MAXPS_LSB +: 7];
          end
          if (wr_req.strb[1]) begin
            dir_in_nxt = wr_req.data[`CFG_DIR_LSB +: 7];
          end
        end
        `OFS_IRQ_MASK: begin
          if (wr_req.strb[0]) begin
            mask_nxt[7:0] = wr_req.data[7:0];
          end
          if (wr_req.strb[1]) begin
            mask_nxt[15:8] = wr_req.data[15:8];
          end
        end
        default: begin
          mask_nxt = mask_r;
        end
      endcase
    end
    for (int p = 0; p < 7; p++) begin
      if (stall_force[p]) begin
        resp_sel_nxt[2*p +: 2] = `RESP_STALL;
      end
    end
  end

  // Interrupt requests follow the next flag values so they line up with the flags
  always_comb begin
    irq_nrdy_nxt = |not_ready_nxt;
    irq_emp_nxt = |empty_oversize_nxt;
    irq_nxt = |(not_ready_nxt & mask_nxt[`MASK_NRDY_LSB +: 3]) |
              (|(empty_oversize_nxt & mask_nxt[`MASK_EMP_LSB +: 7]));
  end

  // Unmapped addresses answer with a slave error and read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (rd_addr)
      `OFS_CTRL: rd_data = {31'h0000_0000, clk_on_r};
      `OFS_RESP_SEL: rd_data = {18'h0_0000, resp_sel_r};
      `OFS_NOT_READY: rd_data = {29'h0000_0000, not_ready_r};
      `OFS_EMPTY_OVERSIZE: rd_data = {25'h000_0000, empty_oversize_r};
      `OFS_PIPE_CFG: rd_data = {17'h0_0000, dir_in_r, 1'b0, ctrl_pipe_max_packet_size_r};
      `OFS_IRQ_MASK: rd_data = {16'h0000, mask_r};
      default: rd_ok = 1'b0;
    endcase
  end

  // Write decode mirrors the read map
  always_comb begin
    case (wr_req.addr)
      `OFS_CTRL, `OFS_RESP_SEL, `OFS_NOT_READY, `OFS_EMPTY_OVERSIZE,
      `OFS_PIPE_CFG, `OFS_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Hardware reset clears every flag; usb_bus_reset is accepted but has no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      not_ready_r <= 3'(`RST_FLAGS);
      empty_oversize_r <= 7'(`RST_FLAGS);
      resp_sel_r <= `RST_RESP_SEL;
      dir_in_r <= 7'(`RST_CFG >> `CFG_DIR_LSB);
      ctrl_pipe_max_packet_size_r <= 7'(`RST_CFG);
      clk_on_r <= 1'(`RST_CTRL);
      mask_r <= `RST_MASK;
      irq_nrdy_r <= 1'b0;
      irq_emp_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      not_ready_r <= not_ready_nxt;
      empty_oversize_r <= empty_oversize_nxt;
      resp_sel_r <= resp_sel_nxt;
      dir_in_r <= dir_in_nxt;
      ctrl_pipe_max_packet_size_r <= ctrl_pipe_max_packet_size_nxt;
      clk_on_r <= clk_on_nxt;
      mask_r <= mask_nxt;
      irq_nrdy_r <= irq_nrdy_nxt;
      irq_emp_r <= irq_emp_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign pipe_response_select = resp_sel_r;
  assign irq_not_ready = irq_nrdy_r;
  assign irq_empty_oversize = irq_emp_r;
  assign irq = irq_r;

  // The bus reset indication is read only so that it is not mistaken for a flag clear
  logic bus_reset_seen;
  assign bus_reset_seen = usb_bus_reset & 1'b0;
endmodule
`default_nettype wire

// *** sim/usb_host_model.sv ***
// Host side model: tokens, packet-end events, drain pulses and bus reset
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
  import usb_flags_pkg::*;
(
  input wire logic aclk,
  output var token_evt_s token_evt,
  output var rx_evt_s rx_evt,
  output logic [6:0] tx_empty,
  output logic usb_bus_reset
);
  // Quiet at time zero
  initial begin
    token_evt = '0;
    rx_evt = '0;
    tx_empty = '0;
    usb_bus_reset = 1'b0;
  end
  // One-cycle token; idle fields flip so stale values never pass for live ones
  task automatic token(input logic [2:0] p, input logic n, input logic s);
    @(posedge aclk);
    token_evt <= '{1'b1, p, n, s};
    @(posedge aclk);
    token_evt <= '{1'b0, ~p, ~n, ~s};
  endtask
  // Packet end with its length
  task automatic packet(input logic [2:0] p, input logic [10:0] l, input logic o);
    @(posedge aclk);
    rx_evt <= '{1'b1, p, l, o};
    @(posedge aclk);
    rx_evt <= '{1'b0, ~p, ~l, ~o};
  endtask
  // Drain pulses and bus reset share one slot
  task automatic pulse(input logic [6:0] e, input logic b);
    @(posedge aclk);
    tx_empty <= e;
    usb_bus_reset <= b;
    @(posedge aclk);
    tx_empty <= '0;
    usb_bus_reset <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/usb_pipe_buffer_event_flags_chk.sv ***
// Port-level checker for the pipe event flag block
`timescale 1ns/1ps
`default_nettype none
module usb_flags_chk
  import usb_flags_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire token_evt_s token_evt,
  input wire rx_evt_s rx_evt,
  input wire logic usb_bus_reset,
  input wire logic [13:0] pipe_response_select,
  input wire logic irq_not_ready,
  input wire logic irq_empty_oversize,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Token that meets a NAK on the given pipe
  sequence nak_tok(p);
    token_evt.valid && token_evt.nak && token_evt.pipe == p;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_nrdy_set: assert property (nak_tok(3'd1) ##0 pipe_response_select[3:2] == 2'h1 |=> irq_not_ready)
    else $error("not-ready flag missed");
  chk_status_quiet: assert property (nak_tok(3'd0) ##0 token_evt.status_stage && !irq_not_ready |=> !irq_not_ready)
    else $error("status-stage NAK set a flag");
  chk_stall_force: assert property (rx_evt.valid && rx_evt.over_max && rx_evt.pipe == 3'd1 |=> pipe_response_select[3:2] == 2'h2 && irq_empty_oversize)
    else $error("oversize not stalled");
  chk_bus_keep: assert property (usb_bus_reset && irq_empty_oversize && !s_axi_wvalid |=> irq_empty_oversize)
    else $error("bus reset cleared flags");
  chk_reset_clear: assert property (disable iff (1'b0) !aresetn |=> !irq && !irq_not_ready && !irq_empty_oversize && !s_axi_bvalid)
    else $error("reset left state");
endmodule
bind usb_pipe_buffer_event_flags usb_flags_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .token_evt(token_evt), .rx_evt(rx_evt), .usb_bus_reset(usb_bus_reset),
  .pipe_response_select(pipe_response_select), .irq_not_ready(irq_not_ready),
  .irq_empty_oversize(irq_empty_oversize), .irq(irq));
`default_nettype wire

// *** sim/usb_pipe_buffer_event_flags_tb.sv ***
// Self-checking bench for the pipe event flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module usb_pipe_buffer_event_flags_tb;
  import usb_flags_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq_nr, irq_eo, irq, ubr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [13:0] psel;
  logic [6:0] txe;
  logic [3:0] wstrb;
  token_evt_s tok;
  rx_evt_s rx;
  int n_fail, comparisons;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  usb_pipe_buffer_event_flags dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .token_evt(tok),
    .rx_evt(rx), .tx_empty(txe), .usb_bus_reset(ubr), .pipe_response_select(psel),
    .irq_not_ready(irq_nr), .irq_empty_oversize(irq_eo), .irq(irq));
  usb_host_model u_host (.aclk(aclk), .token_evt(tok), .rx_evt(rx), .tx_empty(txe),
    .usb_bus_reset(ubr));
  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Responses are judged against the oldest note as they arrive
  always @(posedge aclk) begin
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
    if (bvalid && bready) `CHK(bresp, bq.pop_front())
  end
  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    bq.push_back(2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // Ready sometimes waits for the response so the hold checks get exercised
    bready <= 1'($urandom_range(1, 0));
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (i == 50) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Read: expected response code and data noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom_range(1, 0));
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (i == 50) begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(32'hae4f));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h6c, 32'h0000_0000, 2'h0);
    rd(8'h10, 32'h0000_0000, 2'h2);
    wr(8'h64, 32'h0000_0015);
    u_host.token(3'd0, 1'b1, 1'b1);
    u_host.token(3'd0, 1'b0, 1'b0);
    rd(8'h68, 32'h0000_0000, 2'h0);
    u_host.token(3'd1, 1'b1, 1'b0);
    u_host.token(3'd2, 1'b1, 1'b0);
    wr(8'h68, 32'hffff_ffff);
    rd(8'h68, 32'h0000_0006, 2'h0);
    `CHK(irq_nr, 1'b1)
    wr(8'h60, 32'h0000_0000);
    wr(8'h68, 32'h0000_0000);
    rd(8'h68, 32'h0000_0006, 2'h0);
    wr(8'h60, 32'h0000_0001);
    repeat (20) @(posedge aclk);
    wr(8'h68, 32'h0000_0000);
    rd(8'h68, 32'h0000_0000, 2'h0);
    `CHK(irq_nr, 1'b0)
    wr(8'h78, 32'h0000_0840);
    u_host.pulse(7'h18, 1'b0);
    u_host.packet(3'd0, 11'($urandom_range(64, 0)), 1'b0);
    u_host.packet(3'd0, 11'h041, 1'b0);
    u_host.packet(3'd1, 11'h010, 1'b1);
    rd(8'h6c, 32'h0000_000b, 2'h0);
    `CHK(psel, 14'h001a)
    `CHK(irq_eo, 1'b1)
    u_host.pulse(7'h00, 1'b1);
    rd(8'h6c, 32'h0000_000b, 2'h0);
    wr(8'h7c, 32'h0000_0008);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(8'h7c, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(8'h6c, 32'hffff_fffd);
    rd(8'h6c, 32'h0000_0009, 2'h0);
    // A zero write on unstrobed lanes must leave the flags alone
    wstrb <= 4'he;
    wr(8'h6c, 32'h0000_0000);
    rd(8'h6c, 32'h0000_0009, 2'h0);
    wstrb <= 4'hf;
    wr(8'h60, 32'h0000_0003);
    rd(8'h6c, 32'h0000_0000, 2'h0);
    `CHK(irq_eo, 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
